// *** wdr_pkg.sv ***
// Constants, types and timing figures for the watchdog and reset delay timer.
// Contract
// - Watchdog counts its own free-running oscillator ticks.
// - Time-out resets device, or wakes it from sleep.
// - Watchdog reset clears the time-out flag.
// - Enable fuse at zero disables watchdog permanently.
// - Long delay after power-on; crystal modes always.
// - RC modes: short delay after non-power-on resets.
// - Processor held in reset while delay counts.
// - Watchdog time-out also starts the delay timer.
package wdr_pkg;

    // Clock period and the two documented delays, in nanoseconds.
    localparam int CLK_PERIOD_NS = 5;
    localparam int HOLD_LONG_NS = 18000000;
    localparam int HOLD_SHORT_NS = 300000;

    // Delays are least times, so the cycle counts round up.
    localparam int HOLD_LONG_CYC = (HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_SHORT_CYC = (HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Counter widths; the long delay needs 22 bits.
    localparam int HOLD_CNT_W = 22;
    localparam int WDOG_CNT_W = 16;

    // Default watchdog period in watchdog oscillator ticks.
    localparam int WDOG_PERIOD_TICKS_DEF = 1024;

    // Reset values of the control state.
    localparam logic HOLD_LONG_RST = 1'b1;
    localparam logic TIMEOUT_FLAG_RST = 1'b1;
    localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_RST = 22'h000000;
    localparam logic [WDOG_CNT_W-1:0] WDOG_CNT_RST = 16'h0000;

    // Oscillator configuration encodings.
    typedef enum logic [1:0] {
        WDR_LOW_POWER_CRYSTAL_MODE = 2'b00,
        WDR_CRYSTAL_OSC_MODE = 2'b01,
        WDR_INTERNAL_RC_OSC_MODE = 2'b10,
        WDR_EXTERNAL_RC_OSC_MODE = 2'b11
    } wdr_osc_mode_t;

    // Top-level state: processor held in reset or running.
    typedef enum logic {
        WDR_ST_DELAY = 1'b0,
        WDR_ST_RUN = 1'b1
    } wdr_state_t;

endpackage

// *** wdr_sync.sv ***
// Two-stage synchroniser with rising-edge pulse for the watchdog oscillator.
`timescale 1ns/10ps
module wdr_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic async_i,
    output logic rise_o
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;
    logic meta_next;
    logic sync_next;
    logic last_next;

    // The first stage feeds only the second; edges are taken from later stages.
    always_comb begin
        meta_next = meta_reg;
        sync_next = sync_reg;
        last_next = last_reg;
        if (ce_i) begin
            meta_next = async_i;
            sync_next = meta_reg;
            last_next = sync_reg;
        end
    end

    // Registers only.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    // One pulse per rising edge of the slow oscillator.
    assign rise_o = ce_i & sync_reg & ~last_reg;

endmodule

// *** wdr_watchdog_reset.sv ***
// Watchdog timer and reset delay timer that hold the processor in reset.
`timescale 1ns/10ps
module wdr_watchdog_reset #(
    parameter logic [wdr_pkg::HOLD_CNT_W-1:0] HOLD_LONG_CYCLES = wdr_pkg::HOLD_CNT_W'(wdr_pkg::HOLD_LONG_CYC),
    parameter logic [wdr_pkg::HOLD_CNT_W-1:0] HOLD_SHORT_CYCLES = wdr_pkg::HOLD_CNT_W'(wdr_pkg::HOLD_SHORT_CYC),
    parameter logic [wdr_pkg::WDOG_CNT_W-1:0] WDOG_PERIOD_TICKS = wdr_pkg::WDOG_CNT_W'(wdr_pkg::WDOG_PERIOD_TICKS_DEF)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic watchdog_osc_i,
    input wire logic watchdog_enable_fuse_i,
    input wire logic [1:0] osc_mode_i,
    input wire logic ext_reset_i,
    input wire logic sleep_i,
    input wire logic watchdog_clear_i,
    input wire logic timeout_flag_set_i,
    output logic core_reset_o,
    output logic device_reset_o,
    output logic wake_reset_o,
    output logic timeout_flag_o
);

    wdr_pkg::wdr_state_t state_reg;
    wdr_pkg::wdr_state_t state_next;
    logic [wdr_pkg::HOLD_CNT_W-1:0] hold_cnt_reg;
    logic [wdr_pkg::HOLD_CNT_W-1:0] hold_cnt_next;
    logic [wdr_pkg::WDOG_CNT_W-1:0] wdog_cnt_reg;
    logic [wdr_pkg::WDOG_CNT_W-1:0] wdog_cnt_next;
    logic hold_long_reg;
    logic hold_long_next;
    logic timeout_flag_reg;
    logic timeout_flag_next;
    logic device_reset_reg;
    logic device_reset_next;
    logic wake_reset_reg;
    logic wake_reset_next;
    logic wdog_tick;
    logic wdog_timeout;
    logic hold_done;
    logic crystal_mode;

    // The watchdog oscillator is a pin from its own free-running source.
    wdr_sync u_wdog_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .async_i(watchdog_osc_i),
        .rise_o(wdog_tick)
    );

    // Crystal modes keep the long delay after every reset.
    assign crystal_mode = (osc_mode_i == wdr_pkg::WDR_CRYSTAL_OSC_MODE) ||
                          (osc_mode_i == wdr_pkg::WDR_LOW_POWER_CRYSTAL_MODE);

    // Time-out needs the fuse; a blown fuse has no runtime override.
    assign wdog_timeout = ce_i && (state_reg == wdr_pkg::WDR_ST_RUN) && watchdog_enable_fuse_i && wdog_tick &&
                          !watchdog_clear_i && (wdog_cnt_reg == WDOG_PERIOD_TICKS - 16'h0001);

    // The delay ends on the last cycle of the selected length.
    assign hold_done = (hold_cnt_reg == ((hold_long_reg ? HOLD_LONG_CYCLES : HOLD_SHORT_CYCLES) - 22'h000001));

    // Watchdog counter: ticks keep arriving during sleep since they do not use the core clock.
    always_comb begin
        wdog_cnt_next = wdog_cnt_reg;
        if (ce_i) begin
            if (state_reg != wdr_pkg::WDR_ST_RUN || !watchdog_enable_fuse_i || watchdog_clear_i || wdog_timeout) begin
                wdog_cnt_next = wdr_pkg::WDOG_CNT_RST;
            end else if (wdog_tick) begin
                wdog_cnt_next = wdog_cnt_reg + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdog_cnt_reg <= wdr_pkg::WDOG_CNT_RST;
        end else begin
            wdog_cnt_reg <= wdog_cnt_next;
        end
    end

    // Reset sequencer: a reset request restarts the delay even if one is already running.
    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        hold_long_next = hold_long_reg;
        device_reset_next = 1'b0;
        wake_reset_next = 1'b0;
        if (ce_i) begin
            if (ext_reset_i || wdog_timeout) begin
                state_next = wdr_pkg::WDR_ST_DELAY;
                hold_cnt_next = wdr_pkg::HOLD_CNT_RST;
                hold_long_next = crystal_mode;
                device_reset_next = ext_reset_i || !sleep_i;
                wake_reset_next = wdog_timeout && sleep_i && !ext_reset_i;
            end else begin
                case (state_reg)
                    wdr_pkg::WDR_ST_DELAY: begin
                        if (hold_done) begin
                            state_next = wdr_pkg::WDR_ST_RUN;
                        end else begin
                            hold_cnt_next = hold_cnt_reg + 22'h000001;
                        end
                    end
                    wdr_pkg::WDR_ST_RUN: begin
                        state_next = wdr_pkg::WDR_ST_RUN;
                    end
                    default: begin
                        state_next = wdr_pkg::WDR_ST_DELAY;
                    end
                endcase
            end
        end
    end

    // Reset is the power-on event, so it always arms the long delay.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= wdr_pkg::WDR_ST_DELAY;
            hold_cnt_reg <= wdr_pkg::HOLD_CNT_RST;
            hold_long_reg <= wdr_pkg::HOLD_LONG_RST;
            device_reset_reg <= 1'b0;
            wake_reset_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            hold_long_reg <= hold_long_next;
            device_reset_reg <= device_reset_next;
            wake_reset_reg <= wake_reset_next;
        end
    end

    // Time-out flag: the time-out clear wins over a software set in the same cycle.
    always_comb begin
        timeout_flag_next = timeout_flag_reg;
        if (ce_i) begin
            if (wdog_timeout) begin
                timeout_flag_next = 1'b0;
            end else if (timeout_flag_set_i) begin
                timeout_flag_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_flag_reg <= wdr_pkg::TIMEOUT_FLAG_RST;
        end else begin
            timeout_flag_reg <= timeout_flag_next;
        end
    end

    // Outputs straight from registers.
    assign core_reset_o = (state_reg == wdr_pkg::WDR_ST_DELAY);
    assign device_reset_o = device_reset_reg;
    assign wake_reset_o = wake_reset_reg;
    assign timeout_flag_o = timeout_flag_reg;

    // Checks kept beside the logic.
    sequence s_timeout;
        wdog_timeout;
    endsequence

    sequence s_delay_started;
        (state_reg == wdr_pkg::WDR_ST_DELAY) && (hold_cnt_reg == wdr_pkg::HOLD_CNT_RST);
    endsequence

    property p_tick_in_sleep;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && sleep_i && wdog_tick && !wdog_timeout && !watchdog_clear_i && watchdog_enable_fuse_i &&
         state_reg == wdr_pkg::WDR_ST_RUN && !ext_reset_i) |=> (wdog_cnt_reg == $past(wdog_cnt_reg) + 16'h0001);
    endproperty
    a_tick_in_sleep: assert property (p_tick_in_sleep) else $error("watchdog missed a tick in sleep");

    property p_awake_reset;
        @(posedge clk_i) disable iff (rst_i)
        (s_timeout and !sleep_i) |=> (device_reset_o && !wake_reset_o) ##1 !device_reset_o;
    endproperty
    a_awake_reset: assert property (p_awake_reset) else $error("time-out while awake gave no device reset");

    property p_sleep_wake;
        @(posedge clk_i) disable iff (rst_i)
        (s_timeout and sleep_i and !ext_reset_i) |=> (wake_reset_o && !device_reset_o);
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("time-out in sleep gave no wake reset");

    property p_flag_cleared;
        @(posedge clk_i) disable iff (rst_i)
        s_timeout |=> !timeout_flag_o;
    endproperty
    a_flag_cleared: assert property (p_flag_cleared) else $error("time-out flag not cleared");

    property p_fuse_off;
        @(posedge clk_i) disable iff (rst_i)
        !watchdog_enable_fuse_i |-> !wdog_timeout ##1 (wdog_cnt_reg == wdr_pkg::WDOG_CNT_RST || !$past(ce_i));
    endproperty
    a_fuse_off: assert property (p_fuse_off) else $error("watchdog active with fuse off");

    property p_crystal_long;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && ext_reset_i && crystal_mode) |=> hold_long_reg and s_delay_started;
    endproperty
    a_crystal_long: assert property (p_crystal_long) else $error("crystal mode reset lacks long delay");

    property p_rc_short;
        @(posedge clk_i) disable iff (rst_i)
        (ce_i && ext_reset_i && !crystal_mode) |=> !hold_long_reg;
    endproperty
    a_rc_short: assert property (p_rc_short) else $error("rc mode reset lacks short delay");

    property p_held_while_counting;
        @(posedge clk_i) disable iff (rst_i)
        (core_reset_o && !hold_done) |=> core_reset_o;
    endproperty
    a_held_while_counting: assert property (p_held_while_counting) else $error("core released early");

    property p_timeout_starts_delay;
        @(posedge clk_i) disable iff (rst_i)
        s_timeout |=> s_delay_started and core_reset_o;
    endproperty
    a_timeout_starts_delay: assert property (p_timeout_starts_delay) else $error("time-out did not start delay");

    property p_period;
        @(posedge clk_i) disable iff (rst_i)
        s_timeout |-> ((wdog_cnt_reg == WDOG_PERIOD_TICKS - 16'h0001) && wdog_tick) ##1
                      (wdog_cnt_reg == wdr_pkg::WDOG_CNT_RST);
    endproperty
    a_period: assert property (p_period) else $error("time-out at wrong count");

endmodule

// *** testbench.sv ***
// Self-checking bench for the watchdog and reset delay timer.
`timescale 1ns/10ps
module testbench;
    typedef struct {logic wake; int len; logic flag;} wdr_note_t;
    logic clk_i, rst_i, ce_i, osc, fuse, ext_reset_i, sleep_i, clr, flag_set;
    logic [1:0] osc_mode_i;
    logic core_reset_o, device_reset_o, wake_reset_o, timeout_flag_o;
    int err_count, cmp_count, n;
    logic exp_flag;
    wdr_note_t notes[$];

    // Short counts keep the run brief; every expectation below derives from 40, 10 and 4.
    wdr_watchdog_reset #(.HOLD_LONG_CYCLES(22'h000028), .HOLD_SHORT_CYCLES(22'h00000A),
        .WDOG_PERIOD_TICKS(16'h0004)) DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .watchdog_osc_i(osc), .watchdog_enable_fuse_i(fuse), .osc_mode_i(osc_mode_i),
        .ext_reset_i(ext_reset_i), .sleep_i(sleep_i), .watchdog_clear_i(clr),
        .timeout_flag_set_i(flag_set), .core_reset_o(core_reset_o), .device_reset_o(device_reset_o),
        .wake_reset_o(wake_reset_o), .timeout_flag_o(timeout_flag_o));

    // The 200 MHz system clock.
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // The watchdog oscillator runs free, also in sleep, at eight system clocks per tick.
    initial begin
        osc = 1'b0;
        forever begin
            repeat (4) @(posedge clk_i);
            #1 osc = ~osc;
        end
    end

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic close_out();
        if (err_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Waits, under a bound, until the processor hold reaches the given level.
    task automatic wait_core(input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (core_reset_o !== lvl) begin
            if (cnt >= lim) begin
                chk(1'b0, "wait for processor hold ran out");
                close_out();
            end
            tick();
            cnt++;
        end
    endtask

    // Delay length in cycles, from the mode in force at the request; the pulse cycle is the first of them.
    function automatic int lenf(input logic [1:0] m);
        if (m == wdr_pkg::WDR_INTERNAL_RC_OSC_MODE || m == wdr_pkg::WDR_EXTERNAL_RC_OSC_MODE) begin
            return 10;
        end
        return 40;
    endfunction

    task automatic ext_pulse();
        notes.push_back('{1'b0, lenf(osc_mode_i), exp_flag});
        ext_reset_i = 1'b1;
        tick();
        ext_reset_i = 0;
    endtask

    // Each reset pulse takes the oldest note; the hold that follows is timed against it.
    initial begin
        wdr_note_t e;
        int cnt;
        bit act;
        act = 0;
        cnt = 0;
        forever begin
            @(posedge clk_i);
            #2;
            if (device_reset_o === 1'b1 || wake_reset_o === 1'b1) begin
                if (notes.size() == 0) begin
                    chk(1'b0, "reset pulse with none expected");
                end else begin
                    e = notes.pop_front();
                    chk(wake_reset_o === e.wake && device_reset_o === !e.wake, "wrong reset kind");
                    chk(timeout_flag_o === e.flag, "time-out flag wrong");
                    act = 1;
                    cnt = 0;
                end
            end
            if (act) begin
                if (core_reset_o === 1'b1) begin
                    cnt++;
                end else begin
                    chk(cnt == e.len, "hold length wrong");
                    act = 0;
                end
            end
        end
    end

    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        fuse = 1'b0;
        ext_reset_i = 1'b0;
        sleep_i = 1'b0;
        clr = 1'b0;
        flag_set = 1'b0;
        osc_mode_i = wdr_pkg::WDR_INTERNAL_RC_OSC_MODE;
        err_count = 0;
        cmp_count = 0;
        exp_flag = 1'b1;
        n = $urandom(23);
        repeat (16) @(posedge clk_i);
        #1 rst_i = 1'b0;
        // Power-on gives the long delay even in an RC mode.
        wait_core(1'b0, 100, n);
        chk(n >= 40 && n <= 42, "power-on delay length");
        chk(timeout_flag_o === 1'b1, "flag after power-on");
        // Later resets in every mode, with random spacing, then a restart in mid-delay.
        for (int m = 0; m < 4; m++) begin
            osc_mode_i = m[1:0];
            repeat ($urandom % 5) tick();
            ext_pulse();
            wait_core(1'b0, 60, n);
        end
        ext_pulse();
        repeat (5) tick();
        ext_pulse();
        wait_core(1'b0, 60, n);
        // A low clock enable freezes the delay, so the hold grows by the seven frozen cycles.
        ext_pulse();
        notes[$].len += 7;
        ce_i = 1'b0;
        repeat (7) tick();
        ce_i = 1'b1;
        wait_core(1'b0, 60, n);
        // With the fuse off the oscillator runs on but nothing may fire.
        repeat (150) tick();
        chk(core_reset_o === 1'b0, "watchdog fired while disabled");
        // Time-outs in every mode, awake or asleep, at random in the RC modes.
        exp_flag = 1'b0;
        for (int m = 0; m < 4; m++) begin
            osc_mode_i = m[1:0];
            // Awake and asleep are both forced once; the RC modes pick at random.
            sleep_i = (m < 2) ? m[0] : 1'($urandom % 2);
            notes.push_back('{sleep_i, lenf(osc_mode_i), 1'b0});
            fuse = 1'b1;
            wait_core(1'b1, 60, n);
            wait_core(1'b0, 60, n);
            fuse = 1'b0;
            sleep_i = 1'b0;
        end
        // Clearing every two ticks starves the time-out; then exactly four ticks expire it.
        fuse = 1'b1;
        repeat (10) begin
            clr = 1'b1;
            tick();
            clr = 1'b0;
            repeat (15) tick();
        end
        notes.push_back('{1'b0, lenf(osc_mode_i), 1'b0});
        clr = 1'b1;
        tick();
        clr = 1'b0;
        wait_core(1'b1, 60, n);
        // Four ticks of eight cycles, the first one to eight cycles after the clear edge.
        chk(n >= 25 && n <= 32, "time-out period after clear");
        wait_core(1'b0, 60, n);
        fuse = 1'b0;
        // The flag survives other resets until software sets it again.
        ext_pulse();
        wait_core(1'b0, 60, n);
        flag_set = 1'b1;
        tick();
        flag_set = 1'b0;
        exp_flag = 1'b1;
        chk(timeout_flag_o === 1'b1, "flag not set again");
        ext_pulse();
        wait_core(1'b0, 60, n);
        repeat (3) tick();
        chk(notes.size() == 0, "expected reset never came");
        close_out();
    end
endmodule
